// ### iex_pkg.sv
// constants and types shared by the expander register access logic
package iex_pkg;

  // **********************************************************
  // bus addressing
  // **********************************************************
  localparam logic [4:0] ADDR_BASE = 5'h1D;
  localparam logic RW_READ = 1'h1;
  localparam logic SDA_ACK = 1'h0;

  // **********************************************************
  // widths and bit counting
  // **********************************************************
  localparam int IDX_W = 3;
  localparam int DATA_W = 8;
  localparam int FIFO_W = 11;
  localparam int FIFO_DEPTH = 8;
  localparam int PIN_SYNC_W = 18;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;
  localparam logic [2:0] PAIR_TOGGLE = 3'h1;
  localparam int REG_CNT = 6;

  // **********************************************************
  // register indices and reset values
  // **********************************************************
  localparam logic [2:0] IDX_IN0 = 3'h0;
  localparam logic [2:0] IDX_IN1 = 3'h1;
  localparam logic [2:0] IDX_OUT0 = 3'h2;
  localparam logic [2:0] IDX_OUT1 = 3'h3;
  localparam logic [2:0] IDX_POL0 = 3'h4;
  localparam logic [2:0] IDX_POL1 = 3'h5;
  localparam logic [2:0] IDX_CFG0 = 3'h6;
  localparam logic [2:0] IDX_CFG1 = 3'h7;
  localparam logic [7:0] RST_OUT = 8'hFF;
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [7:0] RST_CFG = 8'hFF;

  // **********************************************************
  // link states
  // **********************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_CMD = 4'h2,
    ST_WDATA = 4'h3,
    ST_ACK = 4'h4,
    ST_RACK = 4'h5,
    ST_RDATA = 4'h6,
    ST_MACK = 4'h7,
    ST_IGNORE = 4'h8
  } iex_state_t;

endpackage

// ### iex_stream_if.sv
// valid/ready byte stream carrier between the expander modules
`timescale 1ns/1ps
interface iex_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface

// ### iex_sync.sv
// three stage input synchroniser with agreement filter
`timescale 1ns/1ps
module iex_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_ff, s2_ff, s3_ff, stable_ff;
  logic [W-1:0] nxt_stable;

  // a bit changes only once the second and third stages agree
  always_comb
  begin
    nxt_stable = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & stable_ff);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      stable_ff <= RST_VAL;
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      stable_ff <= nxt_stable;
    end
  end

  assign dout = stable_ff;

endmodule

// ### iex_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module iex_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // streams
  iex_stream_if.rx in_s,
  iex_stream_if.tx out_s
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] ONE = {{AW{1'h0}}, 1'h1};

  logic [WIDTH-1:0] mem_ff [0:DEPTH-1];
  logic [AW:0] wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
  logic empty, full, push, pop;

  always_comb
  begin
    empty = (wr_ptr_ff == rd_ptr_ff);
    full = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) && (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
    push = in_s.valid && !full;
    pop = !empty && out_s.ready;
    nxt_wr_ptr = push ? wr_ptr_ff + ONE : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + ONE : rd_ptr_ff;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  // storage needs no reset, it is only read while not empty
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_s.data;
    end
  end

  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem_ff[rd_ptr_ff[AW-1:0]];

endmodule

// ### iex_top.sv
// i2c slave transaction logic of the 16-bit expander with its register file
// Operation
// [R1] answer address 0x74 plus select pins
// [R2] final address bit one reads, zero writes
// [R3] first written byte sets register pointer
// [R4] reads keep pointer until new command
// [R5] write address, command, two data, stop
// [R6] master first writes the register address
// [R7] master repeats start, sends read address
// [R8] ack read request, then transmit on data
// [R9] master acks every byte but the last
// [R10] master nack ends transmission, bus released
// [R11] nack reads until a command arrives
// [R12] repeated start reads commanded register
// [R13] load byte at ack clock rising edge
// [R14] toggle to pair partner at same edge
// [R15] repeated start leaves pointer on partner
// [R16] read length unlimited, ended by nack
// [R17] stop anytime, last acked data valid
// [R18] repeated reads need no new command
// [R19] apply written bytes, step to partner
// [R20] stop releases bus, pointer kept
`timescale 1ns/1ps
module iex_top
  import iex_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // i2c link, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // address select straps
  input wire logic addr_select_low_pin,
  input wire logic addr_select_high_pin,
  // port pins and register contents
  input wire logic [15:0] port_in,
  output logic [15:0] port_out_val,
  output logic [15:0] port_polarity,
  output logic [15:0] port_direction,
  // stall of register updates
  input wire logic apply_hold
);

  // **********************************************************
  // input synchronisers
  // **********************************************************
  logic [1:0] link_sync;
  logic [PIN_SYNC_W-1:0] pin_sync;
  logic scl_f, sda_f;
  logic [15:0] pins_f;
  logic sel_low, sel_high;

  iex_sync #(.W(2), .RST_VAL(2'h3)) u_link_sync (
    .clock(clock),
    .srst(srst),
    .din({scl_in, sda_in}),
    .dout(link_sync)
  );

  iex_sync #(.W(PIN_SYNC_W), .RST_VAL('0)) u_pin_sync (
    .clock(clock),
    .srst(srst),
    .din({addr_select_high_pin, addr_select_low_pin, port_in}),
    .dout(pin_sync)
  );

  assign scl_f = link_sync[1];
  assign sda_f = link_sync[0];
  assign pins_f = pin_sync[15:0];
  assign sel_low = pin_sync[16];
  assign sel_high = pin_sync[17];

  // **********************************************************
  // bus condition detection
  // **********************************************************
  logic scl_prev_ff, sda_prev_ff;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      scl_prev_ff <= 1'h1;
      sda_prev_ff <= 1'h1;
    end
    else
    begin
      scl_prev_ff <= scl_f;
      sda_prev_ff <= sda_f;
    end
  end

  always_comb
  begin
    scl_rise = scl_f && !scl_prev_ff;
    scl_fall = !scl_f && scl_prev_ff;
    start_cond = scl_f && scl_prev_ff && sda_prev_ff && !sda_f;
    stop_cond = scl_f && scl_prev_ff && !sda_prev_ff && sda_f;
  end

  // **********************************************************
  // write fifo toward the register file
  // **********************************************************
  iex_stream_if #(.W(FIFO_W)) fill_s ();
  iex_stream_if #(.W(FIFO_W)) drain_s ();

  iex_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .srst(srst),
    .in_s(fill_s),
    .out_s(drain_s)
  );

  // **********************************************************
  // register file
  // **********************************************************
  logic [7:0] regs_ff [0:REG_CNT-1];
  logic [7:0] nxt_regs [0:REG_CNT-1];
  logic [2:0] drain_idx;
  logic [2:0] drain_slot;

  assign drain_s.ready = !apply_hold;

  always_comb
  begin
    drain_idx = drain_s.data[FIFO_W-1:DATA_W];
    drain_slot = drain_idx - IDX_OUT0;
    for (int i = 0; i < REG_CNT; i++)
    begin
      nxt_regs[i] = regs_ff[i];
    end
    // writes to the input port registers have no effect
    if (drain_s.valid && drain_s.ready && (drain_idx >= IDX_OUT0))
    begin
      nxt_regs[drain_slot] = drain_s.data[DATA_W-1:0]; // [R19]
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      regs_ff[0] <= RST_OUT;
      regs_ff[1] <= RST_OUT;
      regs_ff[2] <= RST_POL;
      regs_ff[3] <= RST_POL;
      regs_ff[4] <= RST_CFG;
      regs_ff[5] <= RST_CFG;
    end
    else
    begin
      for (int i = 0; i < REG_CNT; i++)
      begin
        regs_ff[i] <= nxt_regs[i];
      end
    end
  end

  assign port_out_val = {regs_ff[1], regs_ff[0]};
  assign port_polarity = {regs_ff[3], regs_ff[2]};
  assign port_direction = {regs_ff[5], regs_ff[4]};

  // **********************************************************
  // link state machine
  // **********************************************************
  iex_state_t state_ff, nxt_state, ret_ff, nxt_ret;
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] tx_ff, nxt_tx;
  logic [2:0] ptr_ff, nxt_ptr;
  logic ptr_valid_ff, nxt_ptr_valid;
  logic byte_done_ff, nxt_byte_done;
  logic more_ff, nxt_more;
  logic sda_oe_ff, nxt_sda_oe;
  logic sda_out_ff;
  logic [7:0] cur_byte;
  logic [2:0] ptr_slot;
  logic addr_hit;

  always_comb
  begin
    ptr_slot = ptr_ff - IDX_OUT0;
    case (ptr_ff)
      IDX_IN0: cur_byte = pins_f[7:0];
      IDX_IN1: cur_byte = pins_f[15:8];
      default: cur_byte = regs_ff[ptr_slot];
    endcase
    addr_hit = (shift_ff[7:1] == {ADDR_BASE, sel_high, sel_low}); // [R1]
  end

  assign fill_s.valid = (state_ff == ST_WDATA) && scl_fall && byte_done_ff && !start_cond
    && !stop_cond;
  assign fill_s.data = {ptr_ff, shift_ff};

  always_comb
  begin
    nxt_state = state_ff;
    nxt_ret = ret_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_tx = tx_ff;
    nxt_ptr = ptr_ff;
    nxt_ptr_valid = ptr_valid_ff;
    nxt_byte_done = byte_done_ff;
    nxt_more = more_ff;
    nxt_sda_oe = sda_oe_ff;
    if (start_cond)
    begin
      // pointer untouched, a fetched byte is simply dropped
      nxt_state = ST_ADDR; // [R7] [R15]
      nxt_bit_cnt = BIT_FIRST;
      nxt_byte_done = 1'h0;
      nxt_sda_oe = 1'h0;
    end
    else if (stop_cond)
    begin
      nxt_state = ST_IDLE; // [R17] [R20]
      nxt_byte_done = 1'h0;
      nxt_sda_oe = 1'h0;
    end
    else
    begin
      case (state_ff)
        ST_ADDR, ST_CMD, ST_WDATA:
        begin
          if (scl_rise)
          begin
            nxt_shift = {shift_ff[6:0], sda_f};
            nxt_bit_cnt = bit_cnt_ff + BIT_STEP;
            nxt_byte_done = (bit_cnt_ff == BIT_LAST);
          end
          else if (scl_fall && byte_done_ff)
          begin
            nxt_byte_done = 1'h0;
            nxt_state = ST_IGNORE;
            if (state_ff == ST_ADDR)
            begin
              if (addr_hit && (shift_ff[0] == RW_READ)) // [R2]
              begin
                if (ptr_valid_ff)
                begin
                  nxt_state = ST_RACK; // [R8] [R12] [R18]
                  nxt_sda_oe = 1'h1;
                end
                // without a pointer the read is refused and ignored
              end // [R11]
              else if (addr_hit)
              begin
                nxt_state = ST_ACK; // [R6]
                nxt_ret = ST_CMD;
                nxt_sda_oe = 1'h1;
              end
            end
            else if (state_ff == ST_CMD)
            begin
              nxt_ptr = shift_ff[IDX_W-1:0]; // [R3] [R4]
              nxt_ptr_valid = 1'h1;
              nxt_state = ST_ACK;
              nxt_ret = ST_WDATA;
              nxt_sda_oe = 1'h1;
            end
            else if (fill_s.ready)
            begin
              nxt_ptr = ptr_ff ^ PAIR_TOGGLE; // [R5] [R19]
              nxt_state = ST_ACK;
              nxt_ret = ST_WDATA;
              nxt_sda_oe = 1'h1;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            nxt_sda_oe = 1'h0;
            nxt_state = ret_ff;
            nxt_bit_cnt = BIT_FIRST;
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            nxt_tx = cur_byte; // [R13]
            nxt_ptr = ptr_ff ^ PAIR_TOGGLE; // [R14]
          end
          else if (scl_fall)
          begin
            nxt_state = ST_RDATA;
            nxt_bit_cnt = BIT_FIRST;
            nxt_sda_oe = !tx_ff[7]; // [R8]
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_ff == BIT_LAST)
            begin
              nxt_state = ST_MACK;
              nxt_sda_oe = 1'h0;
            end
            else
            begin
              nxt_tx = {tx_ff[6:0], 1'h0};
              nxt_bit_cnt = bit_cnt_ff + BIT_STEP;
              nxt_sda_oe = !tx_ff[6];
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            nxt_more = (sda_f == SDA_ACK); // [R9] [R16]
            if (sda_f == SDA_ACK)
            begin
              nxt_tx = cur_byte; // [R13]
              nxt_ptr = ptr_ff ^ PAIR_TOGGLE; // [R14]
            end
          end
          else if (scl_fall)
          begin
            nxt_bit_cnt = BIT_FIRST;
            if (more_ff)
            begin
              nxt_state = ST_RDATA;
              nxt_sda_oe = !tx_ff[7];
            end
            else
            begin
              nxt_state = ST_IGNORE; // [R10]
            end
          end
        end
        ST_IDLE, ST_IGNORE:
        begin
          nxt_sda_oe = 1'h0;
        end
        default:
        begin
          nxt_state = ST_IDLE;
          nxt_sda_oe = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_ff <= ST_IDLE;
      ret_ff <= ST_IDLE;
      bit_cnt_ff <= BIT_FIRST;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= IDX_IN0;
      ptr_valid_ff <= 1'h0;
      byte_done_ff <= 1'h0;
      more_ff <= 1'h0;
      sda_oe_ff <= 1'h0;
      sda_out_ff <= 1'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      ret_ff <= nxt_ret;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      tx_ff <= nxt_tx;
      ptr_ff <= nxt_ptr;
      ptr_valid_ff <= nxt_ptr_valid;
      byte_done_ff <= nxt_byte_done;
      more_ff <= nxt_more;
      sda_oe_ff <= nxt_sda_oe;
      sda_out_ff <= 1'h0;
    end
  end

  assign sda_oe = sda_oe_ff;
  assign sda_out = sda_out_ff;

endmodule

// ### iex_top_chk.sv
// concurrent checks on the ports of the expander register access logic
`timescale 1ns/1ps
module iex_top_chk
  import iex_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // i2c link
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // straps and ports
  input wire logic addr_select_low_pin,
  input wire logic addr_select_high_pin,
  input wire logic [15:0] port_in,
  input wire logic [15:0] port_out_val,
  input wire logic [15:0] port_polarity,
  input wire logic [15:0] port_direction,
  input wire logic apply_hold
);
  // ********
  // checks
  // ********
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  sda_out_zero_a:
    assert property (sda_out == 1'h0)
    else $error("data output not held low");
  reset_values_a:
    assert property ($fell(srst) |-> port_out_val == {RST_OUT, RST_OUT} &&
      port_polarity == {RST_POL, RST_POL} && port_direction == {RST_CFG, RST_CFG})
    else $error("port registers not at reset values");
  reset_release_a:
    assert property ($fell(srst) |-> !sda_oe)
    else $error("data driven right after reset");
  oe_scl_low_a:
    assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data enable changed while clock high");
  ack_stands_a:
    assert property ($rose(sda_oe) |=> sda_oe [*7])
    else $error("driven slot too short");
  release_stands_a:
    assert property ($fell(sda_oe) |=> !sda_oe [*7])
    else $error("released slot too short");
  hold_freeze_a:
    assert property (apply_hold [*3] |=> $stable(port_out_val) &&
      $stable(port_polarity) && $stable(port_direction))
    else $error("port registers changed while held");
  stop_release_a:
    assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> !sda_oe [*8])
    else $error("data driven after stop");
endmodule

// ### iex_master_model.sv
// i2c bus master model driving the link clock and data
`timescale 1ns/1ps
module iex_master_model (
  // clock
  input wire logic clock,
  // link, data is released or pulled low
  output logic scl,
  output logic master_oe,
  input wire logic sda
);
  // ********
  // bus phases: start and stop phases 24 cycles, a bit slot 8 cycles (200 ns)
  // ********
  initial
  begin
    scl = 1'h1;
    master_oe = 1'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  // start or repeated start: data falls while clock high
  task automatic start();
    master_oe = 1'h0;
    tick(8);
    scl = 1'h1;
    tick(8);
    master_oe = 1'h1;
    tick(8);
    scl = 1'h0;
  endtask

  // stop: data rises while clock high
  task automatic stop();
    tick(2);
    master_oe = 1'h1;
    tick(6);
    scl = 1'h1;
    tick(8);
    master_oe = 1'h0;
    tick(8);
  endtask

  // long low phase: the slave answers about 4.5 cycles after the fall, and its
  // filtered data must settle before it sees the clock rise, or it finds a false start
  task automatic bit_slot(input logic v, output logic s);
    tick(1);
    master_oe = !v;
    tick(5);
    scl = 1'h1;
    tick(1);
    s = sda;
    tick(1);
    scl = 1'h0;
  endtask

  // msb first, ninth slot released for the slave answer
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_slot(b[i], s);
    bit_slot(1'h1, ack);
  endtask

  // data released while slave sends; ack all but the last
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_slot(1'h1, s);
      b[i] = s;
    end
    bit_slot(last, s);
  endtask
endmodule

// ### i2c_expander_register_access_tb_top.sv
// self-checking bench for the expander register access logic
`timescale 1ns/1ps
module i2c_expander_register_access_tb_top
  import iex_pkg::*;
();
  localparam logic NAK = ~SDA_ACK;
  localparam logic [7:0] ADR_W = {ADDR_BASE, 2'h2, 1'h0};
  localparam logic [7:0] ADR_R = {ADDR_BASE, 2'h2, RW_READ};
  logic clock;
  logic srst;
  logic scl;
  logic master_oe;
  logic sda_out;
  logic sda_oe;
  logic sda_wire;
  logic lo_pin;
  logic hi_pin;
  logic [15:0] port_in;
  logic [15:0] port_out_val;
  logic [15:0] port_polarity;
  logic [15:0] port_direction;
  logic apply_hold;
  logic [7:0] rd;
  logic ack;
  int fails;
  int samples_checked;

  // pulled-up open drain data wire
  assign sda_wire = !(sda_oe | master_oe);

  iex_top iex_top_inst (
    .clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_low_pin(lo_pin),
    .addr_select_high_pin(hi_pin), .port_in(port_in), .port_out_val(port_out_val),
    .port_polarity(port_polarity), .port_direction(port_direction),
    .apply_hold(apply_hold)
  );

  iex_master_model iex_master_model_inst (
    .clock(clock), .scl(scl), .master_oe(master_oe), .sda(sda_wire)
  );

  // ********
  // helpers
  // ********
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic [7:0] b, input logic exp);
    iex_master_model_inst.wbyte(b, ack);
    check({15'h0000, ack}, {15'h0000, exp});
  endtask

  task automatic rb(input logic [7:0] exp, input logic last);
    iex_master_model_inst.rbyte(last, rd);
    check({8'h00, rd}, {8'h00, exp});
  endtask

  task automatic wrap_up();
    $display("checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_addr();
    check(port_direction, {RST_CFG, RST_CFG});
    iex_master_model_inst.start();
    wb({ADDR_BASE, 2'h0, 1'h0}, NAK);
    iex_master_model_inst.stop();
    iex_master_model_inst.start();
    wb(ADR_R, NAK);
    iex_master_model_inst.stop();
    $display("t_addr done");
  endtask

  task automatic t_write();
    iex_master_model_inst.start();
    wb(ADR_W, SDA_ACK);
    wb(8'h02, SDA_ACK);
    wb(8'hA5, SDA_ACK);
    wb(8'h3C, SDA_ACK);
    iex_master_model_inst.stop();
    check(port_out_val, 16'h3CA5);
    // a write to an input port register is acknowledged but changes nothing
    iex_master_model_inst.start();
    wb(ADR_W, SDA_ACK);
    wb(8'h00, SDA_ACK);
    wb(8'h55, SDA_ACK);
    iex_master_model_inst.stop();
    check(port_out_val, 16'h3CA5);
    $display("t_write done");
  endtask

  task automatic t_read();
    iex_master_model_inst.start();
    wb(ADR_W, SDA_ACK);
    wb(8'h03, SDA_ACK);
    iex_master_model_inst.start();
    wb(ADR_R, SDA_ACK);
    rb(8'h3C, 1'h0);
    rb(8'hA5, 1'h1);
    iex_master_model_inst.stop();
    iex_master_model_inst.start();
    wb(ADR_R, SDA_ACK);
    rb(8'h3C, 1'h1);
    iex_master_model_inst.stop();
    $display("t_read done");
  endtask

  task automatic t_restart();
    port_in = 16'h9B61;
    iex_master_model_inst.start();
    wb(ADR_W, SDA_ACK);
    wb(8'h00, SDA_ACK);
    iex_master_model_inst.start();
    wb(ADR_R, SDA_ACK);
    rb(8'h61, 1'h0);
    iex_master_model_inst.start();
    wb(ADR_R, SDA_ACK);
    rb(8'h61, 1'h1);
    iex_master_model_inst.stop();
    $display("t_restart done");
  endtask

  task automatic t_fifo();
    apply_hold = 1'h1;
    iex_master_model_inst.start();
    wb(ADR_W, SDA_ACK);
    wb(8'h04, SDA_ACK);
    for (int i = 1; i <= 8; i++)
      wb(8'(i), SDA_ACK);
    wb(8'h09, NAK);
    iex_master_model_inst.stop();
    check(port_polarity, {RST_POL, RST_POL});
    apply_hold = 1'h0;
    repeat (20) @(negedge clock);
    check(port_polarity, 16'h0807);
    $display("t_fifo done");
  endtask

  // ********
  // clock, reset, sequence
  // ********
  initial
  begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  initial
  begin
    #1000000;
    fails++;
    wrap_up();
  end

  initial
  begin
    srst = 1'h1;
    lo_pin = 1'h0;
    hi_pin = 1'h1;
    port_in = 16'h0000;
    apply_hold = 1'h0;
    fails = 0;
    samples_checked = 0;
    repeat (8) @(negedge clock);
    srst = 1'h0;
    repeat (10) @(negedge clock);
    t_addr();
    t_write();
    t_read();
    t_restart();
    t_fifo();
    wrap_up();
  end
endmodule

bind iex_top iex_top_chk iex_top_chk_inst (
  .clock(clock), .srst(srst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .addr_select_low_pin(addr_select_low_pin),
  .addr_select_high_pin(addr_select_high_pin), .port_in(port_in),
  .port_out_val(port_out_val), .port_polarity(port_polarity),
  .port_direction(port_direction), .apply_hold(apply_hold)
);
